// file: pwm16_timer.sv
/*
  Fast and phase correct PWM engine of a 16-bit timer with three
  compare channels. Assumes a register master on the same clock that
  never asserts read and write strobes together.
*/
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module pwm16_timer
  import pwm16_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic [2:0] pin_out
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Fixed resolution mask for modes 1-3 and 5-7, all ones otherwise.
  function automatic logic [15:0] fixed_mask(input logic [3:0] mode);
    unique case (mode)
      4'h1, 4'h5: fixed_mask = top_8bit;
      4'h2, 4'h6: fixed_mask = top_9bit;
      4'h3, 4'h7: fixed_mask = top_10bit;
      default: fixed_mask = count_max;
    endcase
  endfunction : fixed_mask

  function automatic logic is_fast(input logic [3:0] mode);
    is_fast = (mode inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf});
  endfunction : is_fast

  function automatic logic is_phase(input logic [3:0] mode);
    is_phase = (mode inside {4'h1, 4'h2, 4'h3, 4'ha, 4'hb});
  endfunction : is_phase

  state_t s;
  state_t next_s;
  reg_req_t req;
  logic [15:0] top;
  logic tick;
  logic at_top;
  logic fast;
  logic phase;
  logic [9:0] div_limit;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign fast = is_fast(s.waveform_mode_select);
  assign phase = is_phase(s.waveform_mode_select);

  // ------------------------------------------------------------------
  // TOP selection and prescaler
  // ------------------------------------------------------------------
  always_comb begin
    unique case (s.waveform_mode_select)
      4'he, 4'ha: top = s.capture_value_register;
      4'hf, 4'hb: top = s.compare_active[0];
      default: top = fixed_mask(s.waveform_mode_select);
    endcase
    unique case (s.clk_sel)
      clk_div8: div_limit = div_8;
      clk_div64: div_limit = div_64;
      clk_div256: div_limit = div_256;
      clk_div1024: div_limit = div_1024;
      default: div_limit = 10'h000;
    endcase
  end

  // Timer clock enable from the prescaler.
  assign tick = (s.clk_sel != clk_stop) && (s.prescale == div_limit);
  assign at_top = (s.counter_value == top);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.rdata = 16'h0000;
    next_s.prescale = (s.clk_sel == clk_stop || tick) ? 10'h000
                      : s.prescale + 10'h001;

    // Write-one-to-clear comes first, so a hardware set below wins.
    if (req.wr && req.addr == addr_flags) begin
      if (req.wdata[flag_ovf_bit]) begin
        next_s.overflow_flag = 1'b0;
      end
      if (req.wdata[flag_cap_bit]) begin
        next_s.capture_flag = 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
        if (req.wdata[flag_cmp_lsb + i]) begin
          next_s.compare_flag[i] = 1'b0;
        end
      end
    end

    if (tick) begin
      for (int i = 0; i < 3; i++) begin
        if (s.counter_value == s.compare_active[i]) begin
          next_s.compare_flag[i] = 1'b1;
          unique case (s.output_action_select[i])
            act_noninv: begin
              if (fast) begin
                next_s.compare_output_state[i] = 1'b0;
              end else if (phase) begin
                next_s.compare_output_state[i] = s.count_down;
              end
            end
            act_inv: begin
              if (fast) begin
                next_s.compare_output_state[i] = 1'b1;
              end else if (phase) begin
                next_s.compare_output_state[i] = !s.count_down;
              end
            end
            act_toggle: begin
              if (fast && i == 0) begin
                next_s.compare_output_state[i] =
                  !s.compare_output_state[i];
              end
            end
            default: ;
          endcase
        end
      end
      if (fast) begin
        if (at_top) begin
          next_s.counter_value = bottom;
          next_s.overflow_flag = 1'b1;
          next_s.compare_active = s.compare_buffer;
          if (s.waveform_mode_select == 4'he) begin
            next_s.capture_flag = 1'b1;
          end
          if (s.waveform_mode_select == 4'hf) begin
            next_s.compare_flag[0] = 1'b1;
          end
          for (int i = 0; i < 3; i++) begin
            // Wrap to BOTTOM restores the level a non-inverting or inverting match changed.
            if (s.output_action_select[i] == act_noninv) begin
              next_s.compare_output_state[i] = 1'b1;
            end
            if (s.output_action_select[i] == act_inv) begin
              next_s.compare_output_state[i] = 1'b0;
            end
          end
        end else begin
          next_s.counter_value = s.counter_value + 16'h0001;
        end
      end else if (phase) begin
        if (!s.count_down) begin
          if (at_top) begin
            next_s.count_down = 1'b1;
            next_s.counter_value = s.counter_value - 16'h0001;
            next_s.compare_active = s.compare_buffer;
            if (s.waveform_mode_select == 4'ha) begin
              next_s.capture_flag = 1'b1;
            end
            if (s.waveform_mode_select == 4'hb) begin
              next_s.compare_flag[0] = 1'b1;
            end
          end else begin
            next_s.counter_value = s.counter_value + 16'h0001;
          end
        end else if (s.counter_value == bottom) begin
          next_s.count_down = 1'b0;
          next_s.counter_value = 16'h0001;
          next_s.overflow_flag = 1'b1;
        end else begin
          next_s.counter_value = s.counter_value - 16'h0001;
        end
      end else begin
        // Modes outside the PWM families just count up freely.
        next_s.counter_value = s.counter_value + 16'h0001;
      end
    end

    // Register writes other than the flag clears handled above.
    if (req.wr) begin
      unique case (req.addr)
        addr_control: begin
          next_s.waveform_mode_select = req.wdata[mode_lsb +: 4];
          next_s.clk_sel = clk_sel_t'(req.wdata[clk_sel_lsb +: 3]);
          next_s.output_action_select[0] =
            action_t'(req.wdata[action_a_lsb +: 2]);
          next_s.output_action_select[1] =
            action_t'(req.wdata[action_b_lsb +: 2]);
          next_s.output_action_select[2] =
            action_t'(req.wdata[action_c_lsb +: 2]);
        end
        addr_compare_a, addr_compare_b, addr_compare_c: begin
          for (int i = 0; i < 3; i++) begin
            if (req.addr == addr_compare_a + 4'(i)) begin
              next_s.compare_buffer[i] = req.wdata
                & fixed_mask(s.waveform_mode_select);
              // Outside PWM the compare value is not buffered.
              if (!fast && !phase) begin
                next_s.compare_active[i] = req.wdata;
              end
            end
          end
        end
        addr_capture: next_s.capture_value_register = req.wdata;
        addr_counter: next_s.counter_value = req.wdata;
        addr_flags: ;
        addr_port: begin
          next_s.pin_direction_bit = req.wdata[2:0];
          next_s.port_data = req.wdata[6:4];
        end
        default: ;
      endcase
    end

    if (req.rd) begin
      unique case (req.addr)
        addr_control: next_s.rdata = {2'h0, s.output_action_select,
                                      1'b0, s.clk_sel,
                                      s.waveform_mode_select};
        addr_compare_a: next_s.rdata = s.compare_buffer[0];
        addr_compare_b: next_s.rdata = s.compare_buffer[1];
        addr_compare_c: next_s.rdata = s.compare_buffer[2];
        addr_capture: next_s.rdata = s.capture_value_register;
        addr_counter: next_s.rdata = s.counter_value;
        addr_flags: next_s.rdata = {8'h00, s.compare_output_state,
                                    s.compare_flag, s.capture_flag,
                                    s.overflow_flag};
        addr_port: next_s.rdata = {9'h000, s.port_data, 1'b0,
                                   s.pin_direction_bit};
        default: next_s.rdata = 16'h0000;
      endcase
    end

    // Pin drive: waveform overrides the port only when enabled.
    for (int i = 0; i < 3; i++) begin
      if (!s.pin_direction_bit[i]) begin
        next_s.pins[i] = 1'b0;
      end else if (s.output_action_select[i] == act_off) begin
        next_s.pins[i] = s.port_data[i];
      end else begin
        next_s.pins[i] = s.compare_output_state[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
      s.clk_sel <= clk_stop;
      s.capture_value_register <= value_reset;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_out = s.rdata;
  assign pin_out = s.pins;

endmodule : pwm16_timer

// file: pwm16_pkg.sv
/*
  Constants, types and field layouts for the 16-bit PWM timer block.
  Assumes one 100 MHz clock and a plain address/strobe register port.
*/
package pwm16_pkg;

  // ----------------------------------------------------------------
  // Register map (word addresses on the plain port)
  // ----------------------------------------------------------------
  localparam logic [3:0] addr_control = 4'h0;
  localparam logic [3:0] addr_compare_a = 4'h1;
  localparam logic [3:0] addr_compare_b = 4'h2;
  localparam logic [3:0] addr_compare_c = 4'h3;
  localparam logic [3:0] addr_capture = 4'h4;
  localparam logic [3:0] addr_counter = 4'h5;
  localparam logic [3:0] addr_flags = 4'h6;
  localparam logic [3:0] addr_port = 4'h7;

  // ----------------------------------------------------------------
  // Control and flags register fields
  // ----------------------------------------------------------------
  localparam int mode_lsb = 0;
  localparam int clk_sel_lsb = 4;
  localparam int action_a_lsb = 8;
  localparam int action_b_lsb = 10;
  localparam int action_c_lsb = 12;
  localparam int flag_ovf_bit = 0;
  localparam int flag_cap_bit = 1;
  localparam int flag_cmp_lsb = 2;

  // ----------------------------------------------------------------
  // Reset values and fixed tops
  // ----------------------------------------------------------------
  localparam logic [15:0] control_reset = 16'h0000;
  localparam logic [15:0] value_reset = 16'h0000;
  localparam logic [15:0] top_8bit = 16'h00ff;
  localparam logic [15:0] top_9bit = 16'h01ff;
  localparam logic [15:0] top_10bit = 16'h03ff;
  localparam logic [15:0] count_max = 16'hffff;
  localparam logic [15:0] bottom = 16'h0000;

  // Prescaler divisions in I/O clocks.
  localparam logic [9:0] div_8 = 10'h007;
  localparam logic [9:0] div_64 = 10'h03f;
  localparam logic [9:0] div_256 = 10'h0ff;
  localparam logic [9:0] div_1024 = 10'h3ff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    act_off = 2'h0,
    act_toggle = 2'h1,
    act_noninv = 2'h2,
    act_inv = 2'h3
  } action_t;

  typedef enum logic [2:0] {
    clk_stop = 3'h0,
    clk_div1 = 3'h1,
    clk_div8 = 3'h2,
    clk_div64 = 3'h3,
    clk_div256 = 3'h4,
    clk_div1024 = 3'h5
  } clk_sel_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [3:0] waveform_mode_select;
    clk_sel_t clk_sel;
    action_t [2:0] output_action_select;
    logic [15:0] capture_value_register;
    logic [2:0][15:0] compare_buffer;
    logic [2:0][15:0] compare_active;
    logic [15:0] counter_value;
    logic count_down;
    logic [9:0] prescale;
    logic overflow_flag;
    logic capture_flag;
    logic [2:0] compare_flag;
    logic [2:0] compare_output_state;
    logic [2:0] pin_direction_bit;
    logic [2:0] port_data;
    logic [2:0] pins;
    logic [15:0] rdata;
  } state_t;

endpackage : pwm16_pkg

// file: pwm16_timer_monitor.sv
/*
  Port checker for the PWM timer, bound to every instance below.
  Assumes the register map and strobe timing of the timer package.
*/
`timescale 1ns/1ps
module pwm16_timer_monitor
  import pwm16_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic [2:0] pin_out
);
  logic [3:0] mode;
  logic [2:0] sel;
  logic [2:0] dir;
  logic [15:0] exp_a;
  logic [15:0] cap;
  logic [15:0] top;
  // ----------------------------------------------------------------
  // Shadow of the writes that the properties depend on
  // ----------------------------------------------------------------
  always_comb begin
    case (mode)
      4'h1, 4'h5: top = top_8bit;
      4'h2, 4'h6: top = top_9bit;
      4'h3, 4'h7: top = top_10bit;
      default: top = count_max;
    endcase
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode <= 4'h0;
      sel <= 3'h0;
      dir <= 3'h0;
      exp_a <= 16'h0000;
      cap <= 16'h0000;
    end else if (wr_in) begin
      if (addr_in == addr_control) begin
        mode <= wdata_in[3:0];
        sel <= wdata_in[6:4];
      end
      if (addr_in == addr_port) begin
        dir <= wdata_in[2:0];
      end
      if (addr_in == addr_capture) begin
        cap <= wdata_in;
      end
      if (addr_in == addr_compare_a) begin
        exp_a <= wdata_in & top;
      end
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_rd_idle;
    !$past(rd_in) |-> rdata_out == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped;
    $past(rd_in) && $past(addr_in) > addr_port |-> rdata_out == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_reset_pins;
    $rose(nrst_in) |-> pin_out == 3'h0;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins");
  property p_dir;
    (pin_out & ~(dir | $past(dir) | $past(dir, 2))) == 3'h0;
  endproperty
  a_dir: assert property (p_dir) else $error("undriven pin high");
  property p_stopped;
    sel == 3'h0 && $past(sel) == 3'h0 && !$past(wr_in) && !$past(wr_in, 2)
      |-> $stable(pin_out);
  endproperty
  a_stopped: assert property (p_stopped) else $error("pins moved");
  property p_mask;
    $past(rd_in) && $past(addr_in) == addr_compare_a |-> rdata_out == exp_a;
  endproperty
  a_mask: assert property (p_mask) else $error("compare mask");
  property p_capture;
    $past(rd_in) && $past(addr_in) == addr_capture |-> rdata_out == cap;
  endproperty
  a_capture: assert property (p_capture) else $error("capture value");
  property p_top;
    $past(rd_in) && $past(addr_in) == addr_counter && top != count_max
      |-> rdata_out <= top;
  endproperty
  a_top: assert property (p_top) else $error("count above top");
endmodule : pwm16_timer_monitor

bind pwm16_timer pwm16_timer_monitor mon (
  .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .pin_out(pin_out)
);

// file: pwm_load.sv
/*
  Load on the three PWM pins: counts the cycles each pin is high.
  Assumes the bench pulses clear_in before each measurement window.
*/
`timescale 1ns/1ps
module pwm_load (
  input wire logic clk_in,
  input wire logic clear_in,
  input wire logic [2:0] pin_in,
  output logic [2:0][15:0] high_out
);
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 3; i++) begin
      high_out[i] <= clear_in ? 16'h0000 : high_out[i] + 16'(pin_in[i]);
    end
  end
endmodule : pwm_load

// file: pwm16_timer_tb.sv
/*
  Self-checking bench: register checks, then a table of PWM set-ups
  whose duty is measured by the pin load. Assumes the bound checker.
*/
`timescale 1ns/1ps
module pwm16_timer_tb
  import pwm16_pkg::*;
;
  typedef struct packed {
    logic [15:0] m;
    logic [15:0] v;
  } note_t;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic [2:0] pin_out;
  logic clear = 1'b0;
  logic pend = 1'b0;
  logic [2:0][15:0] high;
  logic [15:0] rows [12][11];
  logic [15:0] mk [3] = '{16'h00ff, 16'h01ff, 16'h03ff};
  logic [15:0] r;
  note_t notes[$];
  note_t n;
  int mismatches = 0;
  int samples_checked = 0;

  always #5 clk_in = ~clk_in;
  pwm16_timer uut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pin_out(pin_out));
  pwm_load load (.clk_in(clk_in), .clear_in(clear), .pin_in(pin_out),
    .high_out(high));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] m,
                    input logic [15:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    notes.push_back(note_t'{m, v});
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask : rd
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Read data stands only in the cycle after the strobe.
  always @(posedge clk_in) begin
    pend <= rd_in;
    if (pend) begin
      n = notes.pop_front();
      check(rdata_out & n.m, n.v);
    end
  end

  initial begin
    // Control, compares A B C, port, window, flags, count mask, highs.
    // Compares stay at or below TOP and TOP is never below 3.
    rows = '{
      '{16'h2a15, 16'h0040, 16'h0000, 16'h00ff, 16'h0007, 16'h0400,
        16'h001d, 16'hff00, 16'h0104, 16'h0004, 16'h0400},
      '{16'h0f15, 16'h0040, 16'h00ff, 16'h0000, 16'h0047, 16'h0400,
        16'h001d, 16'hff00, 16'h02fc, 16'h0000, 16'h0400},
      '{16'h2115, 16'h0010, 16'h0000, 16'h0080, 16'h0007, 16'h0400,
        16'h001d, 16'hff00, 16'h0200, 16'h0000, 16'h0204},
      '{16'h2e11, 16'h0040, 16'h0040, 16'h0080, 16'h0007, 16'h03fc,
        16'h001d, 16'hff00, 16'h0100, 16'h02fc, 16'h0200},
      '{16'h2e1e, 16'h0003, 16'h0003, 16'h000f, 16'h0007, 16'h0400,
        16'h001f, 16'hfff0, 16'h0100, 16'h0300, 16'h0400},
      '{16'h391f, 16'h001f, 16'h0007, 16'h0007, 16'h0007, 16'h0400,
        16'h001d, 16'hffe0, 16'h0200, 16'h0100, 16'h0300},
      '{16'h392f, 16'h001f, 16'h0007, 16'h0007, 16'h0007, 16'h2000,
        16'h001d, 16'hffe0, 16'h1000, 16'h0800, 16'h1800},
      '{16'h0e1a, 16'h0004, 16'h0004, 16'h0000, 16'h0007, 16'h03fc,
        16'h001f, 16'hfff0, 16'h0110, 16'h02ec, 16'h0000},
      '{16'h2c3b, 16'h000f, 16'h0004, 16'h0004, 16'h0017, 16'h0780,
        16'h001d, 16'hfff0, 16'h0780, 16'h0580, 16'h0200},
      '{16'h2e16, 16'h00ff, 16'h01ff, 16'h0000, 16'h0007, 16'h0400,
        16'h001d, 16'hfe00, 16'h0200, 16'h0000, 16'h0002},
      '{16'h2e4e, 16'h0003, 16'h0003, 16'h000f, 16'h0007, 16'h1000,
        16'h001f, 16'hfff0, 16'h0400, 16'h0c00, 16'h1000},
      '{16'h2e5e, 16'h0003, 16'h0003, 16'h000f, 16'h0007, 16'h4000,
        16'h001f, 16'hfff0, 16'h1000, 16'h3000, 16'h4000}};
    void'($urandom(34768));
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(addr_control, 16'hffff, 16'h0000);
    rd(addr_flags, 16'h00ff, 16'h0000);
    check({13'h0000, pin_out}, 16'h0000);
    wr(4'hc, 16'hffff);
    rd(4'hc, 16'hffff, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wr(addr_control, 16'(i < 3 ? i + 1 : i + 2));
      r = 16'($urandom);
      wr(addr_compare_a, r);
      rd(addr_compare_a, 16'hffff, r & mk[i % 3]);
    end
    $display("test mask done");
    for (int k = 0; k < 12; k++) begin
      wr(addr_control, rows[k][0] & 16'hff0f);
      wr(addr_capture, 16'h000f);
      for (int j = 0; j < 3; j++) begin
        wr(4'(addr_compare_a + j), rows[k][1 + j]);
      end
      wr(addr_counter, 16'h0000);
      wr(addr_port, rows[k][4]);
      wr(addr_control, rows[k][0]);
      repeat (rows[k][5]) @(posedge clk_in);
      wr(addr_flags, 16'h00ff);
      clear <= 1'b1;
      @(posedge clk_in);
      clear <= 1'b0;
      repeat (rows[k][5]) @(posedge clk_in);
      #1;
      for (int j = 0; j < 3; j++) begin
        check(high[j], rows[k][8+j]);
      end
      rd(addr_flags, 16'h001f, rows[k][6]);
      rd(addr_counter, rows[k][7], 16'h0000);
      $display("test pwm row %0d done", k);
    end
    // Capture TOP is lowered below the count while running.
    wr(addr_control, 16'h000e);
    wr(addr_capture, 16'h00ff);
    wr(addr_counter, 16'h0080);
    wr(addr_control, 16'h2a1e);
    wr(addr_capture, 16'h0010);
    rd(addr_capture, 16'hffff, 16'h0010);
    rd(addr_counter, 16'hff80, 16'h0080);
    wr(addr_port, 16'h0070);
    repeat (300) @(posedge clk_in);
    check({13'h0000, pin_out}, 16'h0000);
    $display("test capture and direction done");
    repeat (4) @(posedge clk_in);
    final_report();
  end
endmodule : pwm16_timer_tb
